/* design/udb_pkg.sv */
package udb_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int DATA_W        = 16;
  localparam int LEN_W         = 16;
  localparam int CNT_W         = 8;
  localparam int MODE_W        = 3;
  localparam int NUM_MODES     = 7;
  localparam int SYNC_LAT      = 2;
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [2:0] MODE_MAX = 3'h6;

  // ----------------------------------------------------------------
  // Per-mode timing, picoseconds, mode 0 first
  // ----------------------------------------------------------------
  typedef int udb_ps_tab_t [NUM_MODES];

  localparam udb_ps_tab_t DVS_PS =
    '{72900, 50900, 33900, 22600, 9500, 6000, 5200};
  localparam udb_ps_tab_t DVH_PS =
    '{9000, 9000, 9000, 9000, 9000, 6000, 5200};
  localparam udb_ps_tab_t CYC_PS =
    '{120000, 80000, 60000, 40000, 30000, 20000, 15000};
  localparam udb_ps_tab_t ZIORDY_PS =
    '{20000, 20000, 20000, 20000, 20000, 20000, 20000};
  localparam udb_ps_tab_t ZAD_PS =
    '{0, 0, 0, 0, 0, 0, 0};
  localparam udb_ps_tab_t FS_PS =
    '{230000, 200000, 170000, 130000, 120000, 90000, 80000};

  // Least times round up, never below one cycle
  function automatic int min_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest times round down; input sync latency is spent first
  function automatic int max_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS - SYNC_LAT;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Burst sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_ACK,
    ST_ZIORDY,
    ST_WAIT_GO,
    ST_ZAD,
    ST_SETUP,
    ST_HOLD,
    ST_DONE
  } udb_state_t;

endpackage

/* design/udb_word_if.sv */
interface udb_word_if;
  logic [udb_pkg::DATA_W-1:0] word;
  logic                       avail;
  logic                       take;

  modport prod (
    output word,
    output avail,
    input  take
  );

  modport cons (
    input  word,
    input  avail,
    output take
  );
endinterface

/* design/udb_word_cdc.sv */
module udb_word_cdc (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       link_clk,
  input  wire logic                       link_rst,
  input  wire logic [udb_pkg::DATA_W-1:0] src_word,
  input  wire logic                       src_valid,
  output logic                            src_ready,
  udb_word_if.prod                        wif
);

  // ----------------------------------------------------------------
  // Link side: one word in flight, toggle request
  // ----------------------------------------------------------------
  logic [udb_pkg::DATA_W-1:0] hold_r;
  logic                       req_t_r;
  logic                       ready_r;
  logic                       ack_s1_r;
  logic                       ack_s2_r;
  logic                       ack_t_r;
  logic                       req_s1_r;
  logic                       req_s2_r;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_t_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      hold_r  <= 16'h0000;
      req_t_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (ready_r && src_valid) begin
      // Word stays frozen until the core acknowledges it
      hold_r  <= src_word;
      req_t_r <= ~req_t_r;
      ready_r <= 1'b0;
    end else begin
      ready_r <= (ack_s2_r == req_t_r);
    end
  end

  assign src_ready = ready_r;

  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_t_r  <= 1'b0;
    end else if (ce) begin
      req_s1_r <= req_t_r;
      req_s2_r <= req_s1_r;
      if (wif.take) begin
        ack_t_r <= ~ack_t_r;
      end
    end
  end

  // Holding register is stable for as long as avail is high
  assign wif.word  = hold_r;
  assign wif.avail = (req_s2_r != ack_t_r);

endmodule

/* design/udb_in_burst.sv */
module udb_in_burst (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       link_clk,
  input  wire logic                       link_rst,
  input  wire logic [udb_pkg::DATA_W-1:0] src_word,
  input  wire logic                       src_valid,
  output logic                            src_ready,
  input  wire logic                       start,
  input  wire logic [udb_pkg::LEN_W-1:0]  xfer_len,
  input  wire logic [udb_pkg::MODE_W-1:0] udma_mode,
  input  wire logic                       dmack_n,
  input  wire logic                       stop,
  input  wire logic                       hdmardy_n,
  output logic                            dmarq,
  output logic                            dstrobe,
  output logic                            dstrobe_oe,
  output logic [udb_pkg::DATA_W-1:0]      dd_out,
  output logic                            dd_oe,
  output logic                            busy,
  output logic                            timing_err
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  udb_word_if wif ();

  udb_pkg::udb_state_t         state_r;
  logic [udb_pkg::MODE_W-1:0]  mode_r;
  logic [udb_pkg::CNT_W-1:0]   cnt_r;
  logic [udb_pkg::CNT_W-1:0]   gap_r;
  logic [udb_pkg::CNT_W-1:0]   win_r;
  logic [udb_pkg::LEN_W-1:0]   left_r;
  logic                        first_r;
  logic                        take_r;
  logic                        dmarq_r;
  logic                        strobe_r;
  logic                        strobe_oe_r;
  logic [udb_pkg::DATA_W-1:0]  dd_r;
  logic                        dd_oe_r;
  logic                        err_r;
  logic [2:0]                  sync1_r;
  logic [2:0]                  sync2_r;

  logic [udb_pkg::CNT_W-1:0]   dvs_tab [udb_pkg::NUM_MODES];
  logic [udb_pkg::CNT_W-1:0]   dvh_tab [udb_pkg::NUM_MODES];
  logic [udb_pkg::CNT_W-1:0]   cyc_tab [udb_pkg::NUM_MODES];
  logic [udb_pkg::CNT_W-1:0]   zio_tab [udb_pkg::NUM_MODES];
  logic [udb_pkg::CNT_W-1:0]   zad_tab [udb_pkg::NUM_MODES];
  logic [udb_pkg::CNT_W-1:0]   fs_tab  [udb_pkg::NUM_MODES];

  logic [udb_pkg::CNT_W-1:0]   dvs_c;
  logic [udb_pkg::CNT_W-1:0]   dvh_c;
  logic [udb_pkg::CNT_W-1:0]   cyc_c;
  logic [udb_pkg::CNT_W-1:0]   zio_c;
  logic [udb_pkg::CNT_W-1:0]   zad_c;
  logic [udb_pkg::CNT_W-1:0]   fs_c;
  logic                        ack_on;
  logic                        live;
  logic                        host_go;
  logic                        edge_ok;

  // ----------------------------------------------------------------
  // Word feed from the link clock domain
  // ----------------------------------------------------------------
  udb_word_cdc u_cdc (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .link_clk  (link_clk),
    .link_rst  (link_rst),
    .src_word  (src_word),
    .src_valid (src_valid),
    .src_ready (src_ready),
    .wif       (wif.prod)
  );

  assign wif.take = take_r;

  // ----------------------------------------------------------------
  // Per-mode cycle tables
  // ----------------------------------------------------------------
  for (genvar m = 0; m < udb_pkg::NUM_MODES; m++) begin : g_tab
    assign dvs_tab[m] = udb_pkg::CNT_W'(udb_pkg::min_cyc(udb_pkg::DVS_PS[m]));
    assign dvh_tab[m] = udb_pkg::CNT_W'(udb_pkg::min_cyc(udb_pkg::DVH_PS[m]));
    assign cyc_tab[m] = udb_pkg::CNT_W'(udb_pkg::min_cyc(udb_pkg::CYC_PS[m]));
    assign zio_tab[m] =
      udb_pkg::CNT_W'(udb_pkg::min_cyc(udb_pkg::ZIORDY_PS[m]));
    assign zad_tab[m] = udb_pkg::CNT_W'(udb_pkg::min_cyc(udb_pkg::ZAD_PS[m]));
    assign fs_tab[m]  = udb_pkg::CNT_W'(udb_pkg::max_cyc(udb_pkg::FS_PS[m]));
  end

  assign dvs_c = dvs_tab[mode_r];
  assign dvh_c = dvh_tab[mode_r];
  assign cyc_c = cyc_tab[mode_r];
  assign zio_c = zio_tab[mode_r];
  assign zad_c = zad_tab[mode_r];
  assign fs_c  = fs_tab[mode_r];

  // ----------------------------------------------------------------
  // Host line synchronisers: {hdmardy_n, stop, dmack_n}
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else if (ce) begin
      sync1_r <= {hdmardy_n, stop, dmack_n};
      sync2_r <= sync1_r;
    end
  end

  // Ready and stop roles only count inside the burst envelope
  assign ack_on  = ~sync2_r[0];
  assign live    = dmarq_r && ack_on;
  assign host_go = live && !sync2_r[1] && !sync2_r[2];
  // Pause is seen within sync latency plus one cycle of the pin
  assign edge_ok = host_go && (cnt_r == 8'h00) && (gap_r >= cyc_c);

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= udb_pkg::ST_IDLE;
      mode_r      <= 3'h0;
      cnt_r       <= 8'h00;
      left_r      <= 16'h0000;
      take_r      <= 1'b0;
      dmarq_r     <= 1'b0;
      strobe_r    <= 1'b1;
      strobe_oe_r <= 1'b0;
      dd_r        <= 16'h0000;
      dd_oe_r     <= 1'b0;
    end else if (ce) begin
      take_r <= 1'b0;
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      // DMACK dropping ends every phase once the burst is acknowledged
      if (state_r != udb_pkg::ST_IDLE && state_r != udb_pkg::ST_WAIT_ACK
          && !ack_on) begin
        state_r     <= udb_pkg::ST_IDLE;
        dmarq_r     <= 1'b0;
        strobe_oe_r <= 1'b0;
        strobe_r    <= 1'b1;
        dd_oe_r     <= 1'b0;
      end else begin
        case (state_r)
          udb_pkg::ST_IDLE: begin
            if (start && wif.avail && xfer_len != 16'h0000) begin
              mode_r  <= (udma_mode > udb_pkg::MODE_MAX) ?
                         udb_pkg::MODE_MAX : udma_mode;
              left_r  <= xfer_len;
              dmarq_r <= 1'b1;
              state_r <= udb_pkg::ST_WAIT_ACK;
            end
          end
          udb_pkg::ST_WAIT_ACK: begin
            if (ack_on) begin
              cnt_r   <= zio_c - 8'h01;
              state_r <= udb_pkg::ST_ZIORDY;
            end
          end
          udb_pkg::ST_ZIORDY: begin
            if (cnt_r == 8'h00) begin
              strobe_oe_r <= 1'b1;
              strobe_r    <= 1'b1;
              state_r     <= udb_pkg::ST_WAIT_GO;
            end
          end
          udb_pkg::ST_WAIT_GO: begin
            if (host_go) begin
              cnt_r   <= zad_c - 8'h01;
              state_r <= udb_pkg::ST_ZAD;
            end
          end
          udb_pkg::ST_ZAD: begin
            if (cnt_r == 8'h00) begin
              dd_oe_r <= 1'b1;
              dd_r    <= wif.word;
              take_r  <= 1'b1;
              left_r  <= left_r - 16'h0001;
              cnt_r   <= dvs_c - 8'h01;
              state_r <= udb_pkg::ST_SETUP;
            end
          end
          udb_pkg::ST_SETUP: begin
            if (edge_ok) begin
              strobe_r <= ~strobe_r;
              cnt_r    <= dvh_c - 8'h01;
              state_r  <= udb_pkg::ST_HOLD;
            end
          end
          udb_pkg::ST_HOLD: begin
            if (cnt_r == 8'h00) begin
              if (left_r == 16'h0000) begin
                state_r <= udb_pkg::ST_DONE;
              end else if (wif.avail) begin
                dd_r    <= wif.word;
                take_r  <= 1'b1;
                left_r  <= left_r - 16'h0001;
                cnt_r   <= dvs_c - 8'h01;
                state_r <= udb_pkg::ST_SETUP;
              end
            end
          end
          udb_pkg::ST_DONE: begin
            // Strobe and data stay driven until the host drops DMACK
            state_r <= udb_pkg::ST_DONE;
          end
          default: begin
            state_r <= udb_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge spacing: cycles since the last DSTROBE edge, saturating
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= 8'hFF;
    end else if (ce) begin
      if (state_r == udb_pkg::ST_SETUP && edge_ok) begin
        gap_r <= 8'h01;
      end else if (state_r == udb_pkg::ST_IDLE) begin
        gap_r <= 8'hFF;
      end else if (gap_r != 8'hFF) begin
        gap_r <= gap_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // First-strobe window watch: flags a first negation past tFS
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      win_r   <= 8'h00;
      first_r <= 1'b0;
      err_r   <= 1'b0;
    end else if (ce) begin
      if (state_r == udb_pkg::ST_WAIT_GO && host_go) begin
        win_r   <= 8'h01;
        first_r <= 1'b1;
      end else if (first_r && win_r != 8'hFF) begin
        win_r <= win_r + 8'h01;
      end
      if (first_r && state_r == udb_pkg::ST_SETUP && edge_ok) begin
        first_r <= 1'b0;
        if (win_r > fs_c) begin
          err_r <= 1'b1;
        end
      end
      if (state_r == udb_pkg::ST_IDLE && start) begin
        err_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign dmarq      = dmarq_r;
  assign dstrobe    = strobe_r;
  assign dstrobe_oe = strobe_oe_r;
  assign dd_out     = dd_r;
  assign dd_oe      = dd_oe_r;
  assign timing_err = err_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= (state_r != udb_pkg::ST_IDLE);
    end
  end

endmodule

/* sim/udb_in_burst_asserts.sv */
module udb_in_burst_asserts (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [udb_pkg::MODE_W-1:0] udma_mode,
  input wire logic                       dmack_n,
  input wire logic                       stop,
  input wire logic                       hdmardy_n,
  input wire logic                       dmarq,
  input wire logic                       dstrobe,
  input wire logic                       dstrobe_oe,
  input wire logic [udb_pkg::DATA_W-1:0] dd_out,
  input wire logic                       dd_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------
  // Cycle counts per mode at 5 ns: least for DVS, CYC and DVH, most for FS
  // ------------------------------------------------
  localparam int DVS_C [7] = '{15, 11, 7, 5, 2, 2, 2};
  localparam int CYC_C [7] = '{24, 16, 12, 8, 6, 4, 3};
  localparam int FS_C  [7] = '{46, 40, 34, 26, 24, 18, 16};
  localparam int DVH_C     = 2;

  int         m;
  logic [7:0] eg_r;
  logic [7:0] dg_r;
  logic [7:0] go_r;
  logic       fneg_r;

  // Mode read live: the bench keeps it steady through a burst
  always_comb m = (udma_mode == 3'h7) ? 6 : int'(udma_mode);

  always_ff @(posedge clk) begin
    if (rst) eg_r <= 8'hff;
    else if ($changed(dstrobe)) eg_r <= 8'h01;
    else if (eg_r != 8'hff) eg_r <= eg_r + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (rst) dg_r <= 8'hff;
    else if ($changed(dd_out) || $rose(dd_oe)) dg_r <= 8'h01;
    else if (dg_r != 8'hff) dg_r <= dg_r + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (rst || !dmarq) fneg_r <= 1'b0;
    else if (dstrobe_oe && $fell(dstrobe)) fneg_r <= 1'b1;
  end

  // Counts only while the host is ready, up to the first fall
  always_ff @(posedge clk) begin
    if (rst || !dmarq || fneg_r) go_r <= 8'h00;
    else if (!dmack_n && !stop && !hdmardy_n && go_r != 8'hff)
      go_r <= go_r + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_edge_gap: assert property (
    $changed(dstrobe) && dstrobe_oe |-> eg_r >= CYC_C[m])
    else $error("strobe edges too close");
  chk_data_setup: assert property (
    $changed(dstrobe) && dstrobe_oe |-> dg_r >= DVS_C[m])
    else $error("strobe edge too soon after data");
  chk_data_hold: assert property (
    dd_oe && $past(dd_oe) && $changed(dd_out) |-> eg_r >= DVH_C)
    else $error("data changed too soon after edge");
  chk_req_hold: assert property (
    dmarq && !fneg_r |=> dmarq)
    else $error("request dropped before first fall");
  chk_strobe_keep: assert property (
    dstrobe_oe && !dmack_n |=> dstrobe_oe)
    else $error("strobe released while acknowledged");
  chk_strobe_late: assert property (
    $rose(dstrobe_oe) |-> !$past(dmack_n, 4))
    else $error("strobe driven too soon");
  chk_data_late: assert property (
    $rose(dd_oe) |-> !$past(stop) && !$past(hdmardy_n) && !$past(dmack_n))
    else $error("data driven before host ready");
  chk_role_gate: assert property (
    dstrobe_oe || dd_oe |-> dmarq)
    else $error("lines driven without request");
  chk_pause_edges: assert property (
    (dstrobe_oe && hdmardy_n) [*5] |-> $stable(dstrobe))
    else $error("strobe edge during pause");
  chk_first_fall: assert property (
    dstrobe_oe && !fneg_r |-> go_r < FS_C[m])
    else $error("first strobe fall too late");
endmodule

bind udb_in_burst udb_in_burst_asserts u_chk (
  .clk(clk), .rst(rst), .udma_mode(udma_mode), .dmack_n(dmack_n),
  .stop(stop), .hdmardy_n(hdmardy_n), .dmarq(dmarq), .dstrobe(dstrobe),
  .dstrobe_oe(dstrobe_oe), .dd_out(dd_out), .dd_oe(dd_oe));

/* sim/udb_host_model.sv */
module udb_host_model (
  input  wire logic        clk,
  input  wire logic        dmarq,
  input  wire logic        dstrobe,
  input  wire logic [15:0] dd_out,
  input  wire logic [3:0]  lag,
  input  wire logic        pause,
  input  wire logic [15:0] want,
  output logic             dmack_n,
  output logic             stop,
  output logic             hdmardy_n,
  output logic      [15:0] rx_word,
  output logic             rx_stb
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ds;
  logic hit;
  int   n;

  initial begin
    dmack_n   = 1'b1;
    stop      = 1'b0;
    hdmardy_n = 1'b1;
    rx_stb    = 1'b0;
    rx_word   = 16'h0000;
    forever begin
      @(posedge clk);
      if (dmarq === 1'b1) begin
        stop      <= 1'b1;
        hdmardy_n <= 1'b1;
        repeat (lag + 1) @(posedge clk);
        dmack_n <= 1'b0;
        repeat (lag) @(posedge clk);
        stop      <= 1'b0;
        hdmardy_n <= 1'b0;
        n  = 0;
        ds = dstrobe;
        while (n < want) begin
          @(posedge clk);
          // Extra words after a pause are taken as they come
          hit = dmarq && !dmack_n && (dstrobe !== ds);
          if (hit) begin
            rx_word <= dd_out;
            n++;
          end
          rx_stb    <= hit;
          ds = dstrobe;
          hdmardy_n <= pause && n > 0;
        end
        @(posedge clk);
        rx_stb    <= 1'b0;
        hdmardy_n <= 1'b1;
        repeat (lag + 2) @(posedge clk);
        dmack_n <= 1'b1;
        while (dmarq === 1'b1) @(posedge clk);
      end
    end
  end
endmodule

/* sim/udb_in_burst_tb.sv */
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("Error %0t: got %0h want %0h", $time, a, b); \
  end \
end

module udb_in_burst_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk, rst, link_clk, link_rst;
  logic                       src_valid, src_ready, start, busy;
  logic [15:0]                src_word, xfer_len, rx_word, got, w, exp_w;
  logic [udb_pkg::MODE_W-1:0] udma_mode;
  logic [udb_pkg::DATA_W-1:0] dd_out;
  logic                       dmack_n, stop, hdmardy_n, dmarq, dd_oe;
  logic                       dstrobe, dstrobe_oe, timing_err;
  logic                       rx_stb, pause, pz;
  logic [3:0]                 lag;
  logic [15:0]                feed_q[$], exp_q[$];
  int                         fail_count, cmp_count, pend;
  int                         tick, t_first, t_last;

  // ------------------------------------------------
  // Clocks, design and host
  // ------------------------------------------------
  always #2.5 clk = ~clk;
  always #40 link_clk = ~link_clk;

  udb_in_burst dut (.clk, .rst, .ce(1'b1), .link_clk, .link_rst,
    .src_word, .src_valid, .src_ready, .start, .xfer_len, .udma_mode,
    .dmack_n, .stop, .hdmardy_n, .dmarq, .dstrobe, .dstrobe_oe, .dd_out,
    .dd_oe, .busy, .timing_err);

  udb_host_model host (.clk, .dmarq, .dstrobe, .dd_out, .lag, .pause,
    .want(xfer_len), .dmack_n, .stop, .hdmardy_n, .rx_word, .rx_stb);

  // ------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------
  // Idle word lines flip so a stale value never passes for data
  always @(posedge link_clk) begin
    if (src_valid && src_ready) begin
      src_valid <= 1'b0;
      src_word  <= ~src_word;
    end else if (!src_valid && feed_q.size() > 0) begin
      src_word  <= feed_q.pop_front();
      src_valid <= 1'b1;
    end
  end

  always @(posedge clk)
    if ($urandom_range(0, 15) == 0) pause <= pz && !pause;

  // Expected word is popped once, so a mismatch cannot skew later words
  always @(posedge clk) begin
    tick++;
    if (rx_stb) begin
      exp_w = exp_q.pop_front();
      `CHK(rx_word, exp_w)
      if (got == 16'h0000) t_first = tick;
      t_last = tick;
      got <= got + 16'h0001;
    end
  end

  // Least cycles from first to last word: one edge gap per extra word
  function automatic int min_span(input int len, input int md);
    int c;
    c = (md > 6) ? 6 : md;
    c = (udb_pkg::CYC_PS[c] + udb_pkg::CLK_PERIOD_PS - 1)
        / udb_pkg::CLK_PERIOD_PS;
    return (len - 1) * c;
  endfunction

  task automatic burst(input logic [15:0] len, input logic [2:0] md,
                       input logic pz_i);
    int n;
    for (n = pend; n < len; n++) begin
      w = 16'($urandom);
      feed_q.push_back(w);
      exp_q.push_back(w);
    end
    pend = 0;
    got  = 16'h0000;
    pz   = pz_i;
    @(posedge clk);
    xfer_len  <= len;
    udma_mode <= md;
    lag       <= 4'($urandom_range(1, 3));
    start     <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    start <= 1'b0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    pz = 1'b0;
    `CHK(got, len)
    `CHK(timing_err, 1'b0)
    `CHK(exp_q.size(), 0)
    `CHK(t_last - t_first >= min_span(len, md), 1'b1)
    `CHK(busy, 1'b0)
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {clk, link_clk, rst, link_rst} = 4'h3;
    {src_valid, start, pause, pz} = 4'h0;
    src_word  = 16'h0000;
    xfer_len  = 16'h0000;
    udma_mode = 3'h0;
    lag       = 4'h1;
    void'($urandom(96217));
    repeat (6) @(posedge clk);
    @(posedge link_clk);
    @(posedge clk);
    rst      <= 1'b0;
    link_rst <= 1'b0;
    // A waiting word with zero length must not raise a request
    feed_q.push_back(16'ha5c3);
    exp_q.push_back(16'ha5c3);
    pend = 1;
    repeat (40) @(posedge clk);
    start <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(dmarq, 1'b0)
    start <= 1'b0;
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 8; m++)
        burst(16'($urandom_range(1, 12)), 3'(m), r[0]);
    burst(16'h0001, 3'h6, 1'b0);
    burst(16'h0028, 3'h6, 1'b1);
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
